// [rtl/adc_conversion_serial_readout.sv]
// conversion sequencer with serial result readout, device-clocked or host-clocked
// assumes clock_i is the master clock; serial_clock_i is the host's clock in host-clocked
// mode and is only trusted while chip_select_n_i is low
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - reset release: wake-up then ready falls
// - start conversion within two cycles of request
// - asynchronous request converts within 324 cycles
// - request held low: result every 320
// - ready tied to request: every 324
// - ready falls when each conversion completes
// - sleep exit after 3083 cycles, ready falls
// - role high: device drives clock at half
// - role low: host supplies serial clock
// - msb on output two cycles before ready
// - ready rises seven cycles after last rise
// - first clock rise eight after select falls
// - select high floats data and clock outputs
// - host mode: data floats while select high
// - host mode: ready rises after final falling edge
module adc_conversion_serial_readout
    import adc_readout_pkg::*;
#(
    parameter int WAKE_CYCLES_EXT = adc_readout_pkg::WAKE_EXT_CYCLES,
    parameter int WAKE_CYCLES_INT = adc_readout_pkg::WAKE_INT_CYCLES,
    parameter bit USE_INTERNAL_OSC = 1'b0,
    parameter int FIFO_DEPTH = 4
) (
    // master clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // conversion control pins from the host
    input wire logic convert_request_n_i,
    input wire logic polarity_select_i,
    input wire logic low_power_request_n_i,
    input wire logic port_role_select_i,
    // raw filter output, same clock, two's complement
    input wire logic [23:0] convert_request_n_data_i,
    // serial port
    input wire logic chip_select_n_i,
    input wire logic serial_clock_i,
    output logic serial_clock_o,
    output logic serial_clock_oe_o,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic result_ready_n_o
);
    import adc_readout_pkg::*;

    localparam int WAKE_CYCLES = USE_INTERNAL_OSC ? WAKE_CYCLES_INT : WAKE_CYCLES_EXT;

    generate
        if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CNT_BITS)) begin : g_bad_wake
            $error("wake-up count does not fit the sequencer counter");
        end
        if (FIFO_DEPTH < 2) begin : g_bad_depth
            $error("result buffer needs at least two words");
        end
    endgenerate

    localparam logic [CNT_BITS-1:0] WAKE_LOAD = CNT_BITS'(WAKE_CYCLES - 1);
    localparam logic [CNT_BITS-1:0] CONVERT_REQUEST_N_LAST = CNT_BITS'(CONVERT_REQUEST_N_CYCLES - 1);
    localparam logic [CNT_BITS-1:0] SLEEP_IN_LOAD = CNT_BITS'(SLEEP_ENTRY_CYCLES - 1);
    localparam logic [CNT_BITS-1:0] SLEEP_OUT_LOAD = CNT_BITS'(SLEEP_EXIT_CYCLES - 1);
    localparam logic [3:0] LEAD_LOAD = 4'(MSB_LEAD_CYCLES - 1);
    localparam logic [3:0] GAP_LOAD = 4'(FIRST_SCLK_CYCLES - SYNC_STAGES - 2);
    localparam logic [3:0] TAIL_LOAD = 4'(READY_TAIL_CYCLES - 3);
    localparam logic [BIT_CNT_BITS-1:0] LAST_BIT = BIT_CNT_BITS'(RESULT_BITS - 1);

    // picks one bit of the result, msb first; past the end it reads zero
    function automatic logic bit_at(input logic [23:0] word, input logic [4:0] idx);
        if (idx > LAST_BIT) begin
            return 1'b0;
        end
        return word[LAST_BIT - idx];
    endfunction

    // ---------------------------------------------------------------
    // pin synchronisers: request, polarity, sleep, role, select
    // ---------------------------------------------------------------
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic convert_request_n_req;
    logic pol_sel;
    logic sleep_req;
    logic device_mode;
    logic selected;

    // first stage feeds the second stage only
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta <= 5'h1F;
            pin_sync <= 5'h1F;
        end else begin
            pin_meta <= {chip_select_n_i, port_role_select_i, low_power_request_n_i,
                         polarity_select_i, convert_request_n_i};
            pin_sync <= pin_meta;
        end
    end

    assign convert_request_n_req = !pin_sync[0];
    assign pol_sel = pin_sync[1];
    assign sleep_req = !pin_sync[2];
    assign device_mode = pin_sync[3];
    assign selected = !pin_sync[4];

    // ---------------------------------------------------------------
    // conversion sequencer
    // ---------------------------------------------------------------
    convert_request_n_state_t cv_state;
    logic [CNT_BITS-1:0] cv_cnt;
    logic pol_latched;
    logic wake_done;
    logic push_valid;
    logic push_ready;
    logic cv_last;
    result_word_t push_word;

    assign cv_last = (cv_cnt == CONVERT_REQUEST_N_LAST);
    assign push_valid = (cv_state == CV_HOLD) || (cv_state == CV_RUN && cv_last);
    // polarity is taken at start and held for the whole conversion
    assign push_word.bipolar = pol_latched;
    assign push_word.code = pol_latched ? convert_request_n_data_i : (convert_request_n_data_i ^ CODE_SIGN_FLIP);

    // reset drops any conversion in flight and restarts the wake-up count
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cv_state <= CV_WAKE;
            cv_cnt <= WAKE_LOAD;
            wake_done <= 1'b0;
        end else begin
            wake_done <= 1'b0;
            unique case (cv_state)
                CV_WAKE: begin
                    if (cv_cnt == '0) begin
                        wake_done <= 1'b1;
                        cv_state <= CV_IDLE;
                    end else begin
                        cv_cnt <= cv_cnt - 1'b1;
                    end
                end
                CV_IDLE: begin
                    if (convert_request_n_req) begin
                        cv_state <= CV_RUN;
                        cv_cnt <= CNT_BITS'(SYNC_STAGES); // sync time counts
                    end else if (sleep_req) begin
                        cv_state <= CV_SLEEP_IN;
                        cv_cnt <= SLEEP_IN_LOAD;
                    end
                end
                CV_RUN, CV_HOLD: begin
                    if (cv_state == CV_RUN && !cv_last) begin
                        cv_cnt <= cv_cnt + 1'b1;
                    end else if (!push_ready) begin
                        // buffer full: result waits here rather than being lost
                        cv_state <= CV_HOLD;
                    end else if (convert_request_n_req) begin
                        cv_state <= CV_RUN;
                        cv_cnt <= '0;
                    end else begin
                        cv_state <= CV_IDLE;
                    end
                end
                CV_SLEEP_IN: begin
                    if (cv_cnt == '0) begin
                        cv_state <= CV_SLEEP;
                    end else begin
                        cv_cnt <= cv_cnt - 1'b1;
                    end
                end
                CV_SLEEP: begin
                    if (!sleep_req) begin
                        cv_state <= CV_WAKE;
                        cv_cnt <= SLEEP_OUT_LOAD;
                    end
                end
            endcase
        end
    end

    // polarity captured on the start of each conversion
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pol_latched <= 1'b0;
        end else if ((cv_state == CV_IDLE || (push_valid && push_ready)) && convert_request_n_req) begin
            pol_latched <= pol_sel;
        end
    end

    // ---------------------------------------------------------------
    // result buffer between conversion and readout
    // ---------------------------------------------------------------
    logic pop_valid;
    logic pop_ready;
    result_word_t pop_word;

    result_fifo #(
        .WIDTH($bits(result_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_word),
        .out_valid_o(pop_valid),
        .out_ready_i(pop_ready),
        .out_data_o(pop_word)
    );

    // ---------------------------------------------------------------
    // host-clocked side, on the serial clock from the host
    // ---------------------------------------------------------------
    logic link_rst_n;
    logic [BIT_CNT_BITS-1:0] link_bit;
    logic link_done_tgl;
    logic [23:0] tx_word;

    // deselecting clears the bit position, so every frame starts at the msb
    assign link_rst_n = resetn_i && !chip_select_n_i;

    // bits advance on falling edges; host samples on rising edges
    always_ff @(negedge serial_clock_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_bit <= '0;
        end else if (link_bit <= LAST_BIT) begin
            link_bit <= link_bit + 1'b1;
        end
    end

    // one toggle per finished frame, kept across deselect
    always_ff @(negedge serial_clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link_done_tgl <= 1'b0;
        end else if (!chip_select_n_i && link_bit == LAST_BIT) begin
            link_done_tgl <= ~link_done_tgl;
        end
    end

    // frame-done toggle into the master clock domain
    logic done_meta;
    logic done_sync;
    logic done_last;
    logic link_done;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            done_meta <= 1'b0;
            done_sync <= 1'b0;
            done_last <= 1'b0;
        end else begin
            done_meta <= link_done_tgl;
            done_sync <= done_meta;
            done_last <= done_sync;
        end
    end

    assign link_done = done_sync ^ done_last;

    // ---------------------------------------------------------------
    // readout sequencer, master clock domain
    // ---------------------------------------------------------------
    read_state_t rd_state;
    logic [3:0] rd_cnt;
    logic [23:0] shift_word;
    logic [BIT_CNT_BITS-1:0] rise_cnt;
    logic sclk;
    logic ready_n;
    logic wake_pend;

    // a word is taken only when idle and no wake-up notice is waiting
    assign pop_ready = (rd_state == RD_IDLE) && !wake_pend;

    // wake-up notice: the set wins over the take in the same cycle
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_pend <= 1'b0;
        end else if (wake_done) begin
            wake_pend <= 1'b1;
        end else if (rd_state == RD_IDLE) begin
            wake_pend <= 1'b0;
        end
    end

    // tx_word stays still while ready is low, so the host-clock side may read it
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_state <= RD_IDLE;
            rd_cnt <= '0;
            tx_word <= '0;
            shift_word <= '0;
            rise_cnt <= '0;
            sclk <= SCLK_RESET;
            ready_n <= READY_N_RESET;
        end else begin
            unique case (rd_state)
                RD_IDLE: begin
                    if (wake_pend || pop_valid) begin
                        tx_word <= wake_pend ? WAKE_WORD : pop_word.code;
                        shift_word <= wake_pend ? WAKE_WORD : pop_word.code;
                        rd_cnt <= LEAD_LOAD;
                        rd_state <= RD_LEAD;
                    end
                end
                RD_LEAD: begin
                    // msb already on the shifter output before ready drops
                    if (rd_cnt == '0) begin
                        ready_n <= 1'b0;
                        rd_state <= RD_WAIT;
                    end else begin
                        rd_cnt <= rd_cnt - 1'b1;
                    end
                end
                RD_WAIT: begin
                    if (!device_mode) begin
                        if (link_done) begin
                            ready_n <= 1'b1;
                            rd_state <= RD_IDLE;
                        end
                    end else if (selected) begin
                        rd_cnt <= GAP_LOAD;
                        rd_state <= RD_GAP;
                    end
                end
                RD_GAP: begin
                    if (!selected) begin
                        rd_state <= RD_WAIT;
                    end else if (rd_cnt == '0) begin
                        sclk <= 1'b1;
                        rise_cnt <= 5'h01;
                        rd_state <= RD_SHIFT;
                    end else begin
                        rd_cnt <= rd_cnt - 1'b1;
                    end
                end
                RD_SHIFT: begin
                    if (!selected) begin
                        // deselect mid-frame restarts the frame from the msb
                        sclk <= 1'b0;
                        shift_word <= tx_word;
                        rd_state <= RD_WAIT;
                    end else if (sclk) begin
                        sclk <= 1'b0;
                        if (rise_cnt > LAST_BIT) begin
                            rd_cnt <= TAIL_LOAD;
                            rd_state <= RD_TAIL;
                        end else begin
                            shift_word <= {shift_word[22:0], 1'b0};
                        end
                    end else begin
                        sclk <= 1'b1;
                        rise_cnt <= rise_cnt + 1'b1;
                    end
                end
                RD_TAIL: begin
                    if (rd_cnt == '0) begin
                        ready_n <= 1'b1;
                        rd_state <= RD_IDLE;
                    end else begin
                        rd_cnt <= rd_cnt - 1'b1;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pins; the host-clocked data path selects a bit of a held word
    // by a link-clock counter, so no master-clock edge is needed
    // between select falling and the msb appearing
    // ---------------------------------------------------------------
    assign result_ready_n_o = ready_n;
    assign serial_clock_o = sclk;
    assign serial_clock_oe_o = device_mode && selected;
    assign serial_out_oe_o = device_mode ? selected : !chip_select_n_i;
    assign serial_out_o = device_mode ? shift_word[23] : bit_at(tx_word, link_bit);
endmodule // adc_conversion_serial_readout
`default_nettype wire

// [rtl/adc_readout_pkg.sv]
// package: constants, types and states for the conversion sequencer and serial readout
// assumes a single master clock of 40 MHz; figures below are in master-clock cycles except the two given in microseconds
package adc_readout_pkg;

    // master clock rate used to turn microsecond figures into cycles
    localparam int CLK_MHZ = 40;

    // result word
    localparam int RESULT_BITS = 24;
    localparam logic [23:0] CODE_SIGN_FLIP = 24'h800000;
    localparam logic [23:0] WAKE_WORD = 24'h000000;

    // wake-up after reset release
    localparam int WAKE_EXT_CYCLES = 1536;
    localparam int WAKE_INT_US = 120;
    localparam int WAKE_INT_CYCLES = WAKE_INT_US * CLK_MHZ;

    // low-power entry and exit
    localparam int SLEEP_ENTRY_US = 50;
    localparam int SLEEP_ENTRY_CYCLES = SLEEP_ENTRY_US * CLK_MHZ;
    localparam int SLEEP_EXIT_CYCLES = 3083;

    // conversion timing
    localparam int CONVERT_REQUEST_N_CYCLES = 320;
    localparam int START_MAX_CYCLES = 2;

    // device-clocked readout timing
    localparam int MSB_LEAD_CYCLES = 2;
    localparam int FIRST_SCLK_CYCLES = 8;
    localparam int READY_TAIL_CYCLES = 8;

    // synchroniser depth and counter width
    localparam int SYNC_STAGES = 2;
    localparam int CNT_BITS = 16;
    localparam int BIT_CNT_BITS = 5;

    // values after reset
    localparam logic READY_N_RESET = 1'b1;
    localparam logic SCLK_RESET = 1'b0;

    // result carried through the buffer
    typedef struct packed {
        logic bipolar;
        logic [23:0] code;
    } result_word_t;

    typedef enum logic [2:0] {
        CV_WAKE,
        CV_IDLE,
        CV_RUN,
        CV_HOLD,
        CV_SLEEP_IN,
        CV_SLEEP
    } convert_request_n_state_t;

    typedef enum logic [2:0] {
        RD_IDLE,
        RD_LEAD,
        RD_WAIT,
        RD_GAP,
        RD_SHIFT,
        RD_TAIL
    } read_state_t;

endpackage

// [rtl/result_fifo.sv]
// small synchronous fifo holding finished results until the serial port takes them
// assumes both sides run on the same clock; depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_BITS = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PTR_BITS) != DEPTH) begin : g_bad_depth
            $error("result_fifo depth must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_BITS:0] wr_ptr;
    logic [PTR_BITS:0] rd_ptr;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty without a separate count
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign in_ready_o = (wr_ptr[PTR_BITS-1:0] != rd_ptr[PTR_BITS-1:0])
                        || (wr_ptr[PTR_BITS] == rd_ptr[PTR_BITS]);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr[PTR_BITS-1:0]];

    // storage is written only, never reset, so it maps onto plain flops
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr[PTR_BITS-1:0]] <= in_data_i;
        end
    end

    // pointers
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // result_fifo
`default_nettype wire

// [tb/adc_readout_assertions.sv]
// checker: port timing of the sequencer and serial readout
// assumes the role strap only changes while reset is held
`timescale 1ns/1ps
`default_nettype none
module adc_readout_checker #(
    parameter int WAKE_CYCLES_EXT = 1536
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // watched pins
    input wire logic port_role_select_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clock_o,
    input wire logic serial_clock_oe_o,
    input wire logic serial_out_oe_o,
    input wire logic result_ready_n_o
);
    int wake_cnt = -1;
    int since_rise;
    logic sclk_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // cycles since reset release, saturating so it never wraps
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_cnt <= 0;
        end else if (wake_cnt < 100000) begin
            wake_cnt <= wake_cnt + 1;
        end
    end
    // cycles since the device serial clock last rose
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_q <= 1'b0;
            since_rise <= 0;
        end else begin
            sclk_q <= serial_clock_o;
            since_rise <= (serial_clock_o && !sclk_q) ? 1 : since_rise + 1;
        end
    end
    // quiet clock line for five cycles after select falls
    sequence s_gap;
        !serial_clock_o [*5];
    endsequence
    a_dev_float: assert property ((port_role_select_i && chip_select_n_i) [*4]
        |-> !serial_clock_oe_o && !serial_out_oe_o) else $error("pins driven while deselected");
    a_host_float: assert property (!port_role_select_i && chip_select_n_i
        |-> !serial_out_oe_o) else $error("data driven while deselected");
    a_host_drive: assert property ((!port_role_select_i && !chip_select_n_i) [*3]
        |-> serial_out_oe_o) else $error("data not driven while selected");
    a_sclk_half: assert property ($rose(serial_clock_o) |=> $fell(serial_clock_o))
        else $error("serial clock high longer than one cycle");
    a_reset_ready: assert property (disable iff (1'b0) wake_cnt == 0 && !resetn_i |-> result_ready_n_o)
        else $error("ready low in reset");
    a_wake_quiet: assert property (wake_cnt < WAKE_CYCLES_EXT |-> result_ready_n_o)
        else $error("ready before wake-up ends");
    a_wake_ready: assert property (wake_cnt == WAKE_CYCLES_EXT + 8 |-> !result_ready_n_o)
        else $error("ready late after wake-up");
    a_ready_tail: assert property (port_role_select_i && $rose(result_ready_n_o)
        |-> since_rise inside {[7:9]}) else $error("ready rise not 8 after last clock");
    a_first_rise: assert property (port_role_select_i && !result_ready_n_o
        && $fell(chip_select_n_i) |-> s_gap ##[1:5] serial_clock_o)
        else $error("first clock rise not 8 after select");
endmodule // adc_readout_checker
bind adc_conversion_serial_readout adc_readout_checker #(.WAKE_CYCLES_EXT(WAKE_CYCLES_EXT)) chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .port_role_select_i(port_role_select_i),
    .chip_select_n_i(chip_select_n_i), .serial_clock_o(serial_clock_o),
    .serial_clock_oe_o(serial_clock_oe_o), .serial_out_oe_o(serial_out_oe_o),
    .result_ready_n_o(result_ready_n_o));
`default_nettype wire

// [tb/host_reader.sv]
// host model: reads one result word per call
// assumes role_i mirrors the strap; host clock period 6 ns, running only in frames
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    // master clock and mode
    input wire logic clock_i,
    input wire logic role_i,
    // pins seen from the host
    input wire logic sclk_i,
    input wire logic sclk_oe_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    input wire logic ready_n_i,
    output logic cs_n_o,
    output logic sclk_o
);
    // released clock falls to its pull-down; released data reads inverted
    wire logic sclk_w = sclk_oe_i & sclk_i;
    wire logic sdo_w = sdo_oe_i ? sdo_i : ~sdo_i;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    // one frame; lag counts cycles from last bit to ready rise
    task automatic read_word(output logic [23:0] w, output int lag);
        int n;
        w = 24'h000000;
        lag = 0;
        n = 0;
        @(posedge clock_i);
        cs_n_o <= 1'b0;
        if (role_i) begin
            while (n < 24) begin
                @(posedge sclk_w);
                w = {w[22:0], sdo_w};
                n++;
            end
        end else begin
            #20;
            while (n < 24) begin
                sclk_o = 1'b1;
                w = {w[22:0], sdo_w};
                #3 sclk_o = 1'b0;
                #3 n++;
            end
        end
        // select stays low until ready rises
        while (ready_n_i === 1'b0 && lag < 20) begin
            @(negedge clock_i);
            lag++;
        end
        @(posedge clock_i);
        cs_n_o <= 1'b1;
    endtask
endmodule // host_reader
`default_nettype wire

// [tb/test_adc_conversion_serial_readout.sv]
// bench: wake-up, single and held conversions, reset mid-run, both port roles
// assumes a 40 MHz master clock and a shortened wake-up count
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_serial_readout;
    import adc_readout_pkg::*;
    localparam int WAKE = 20;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic convert_request_n_n = 1'b1;
    logic pol = 1'b1;
    logic role = 1'b1;
    logic slp_n = 1'b1;
    logic [23:0] data = 24'h000000;
    logic cs_n, sclk_h, sclk, sclk_oe, serial_out, sdo_oe, ready_n;
    logic [23:0] w;
    int lag;
    int err_count = 0;
    int compares = 0;
    int gap = 0;
    time last_fall = 0;
    always #12.5 clock_i = ~clock_i;
    // spacing of ready falls in master cycles
    always @(negedge ready_n) begin
        gap = int'(($time - last_fall) / 25);
        last_fall = $time;
    end
    adc_conversion_serial_readout #(.WAKE_CYCLES_EXT(WAKE), .USE_INTERNAL_OSC(1'b0)) uut (
        .clock_i(clock_i), .resetn_i(resetn_i), .convert_request_n_i(convert_request_n_n),
        .polarity_select_i(pol), .low_power_request_n_i(slp_n), .port_role_select_i(role),
        .convert_request_n_data_i(data), .chip_select_n_i(cs_n), .serial_clock_i(sclk_h),
        .serial_clock_o(sclk), .serial_clock_oe_o(sclk_oe), .serial_out_o(serial_out),
        .serial_out_oe_o(sdo_oe), .result_ready_n_o(ready_n));
    host_reader rd (.clock_i(clock_i), .role_i(role), .sclk_i(sclk), .sclk_oe_i(sclk_oe),
        .sdo_i(serial_out), .sdo_oe_i(sdo_oe), .ready_n_i(ready_n), .cs_n_o(cs_n), .sclk_o(sclk_h));
    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_span(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // falling-edge samples are settled; capped against a lost strobe
    task automatic wait_ready(output int n);
        n = 0;
        while (ready_n !== 1'b0 && n < 5000) begin
            @(negedge clock_i);
            n++;
        end
    endtask
    task automatic do_reset(input logic r);
        @(posedge clock_i);
        resetn_i <= 1'b0;
        role <= r;
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
    endtask
    task automatic t_wake();
        int n;
        wait_ready(n);
        chk_span(n, WAKE, WAKE + 6);
        repeat (10) @(negedge clock_i);
        rd.read_word(w, lag);
        chk_word(w, WAKE_WORD);
        $display("wake test done");
    endtask
    task automatic t_single(input logic p, input logic [23:0] d);
        int n;
        @(posedge clock_i);
        pol <= p;
        data <= d;
        convert_request_n_n <= 1'b0;
        repeat (4) @(posedge clock_i);
        convert_request_n_n <= 1'b1;
        wait_ready(n);
        chk_span(n + 3, 318, 324);
        rd.read_word(w, lag);
        chk_word(w, p ? d : d ^ CODE_SIGN_FLIP);
        chk_span(lag, role ? 7 : 1, role ? 9 : 6);
        $display("single test done");
    endtask
    // request held low: ready falls stay on the 320-cycle grid
    task automatic t_held();
        int n;
        int k;
        @(posedge clock_i);
        pol <= 1'b1;
        data <= 24'h5A0F3C;
        convert_request_n_n <= 1'b0;
        wait_ready(n);
        for (k = 0; k < 3; k++) begin
            rd.read_word(w, lag);
            chk_word(w, 24'h5A0F3C);
            wait_ready(n);
            chk_span(gap, 320, 320);
        end
        @(posedge clock_i);
        convert_request_n_n <= 1'b1;
        while (ready_n === 1'b0) begin
            rd.read_word(w, lag);
            repeat (400) @(negedge clock_i);
        end
        $display("held test done");
    endtask
    // reset mid-conversion: only the wake word follows
    task automatic t_abort();
        @(posedge clock_i);
        convert_request_n_n <= 1'b0;
        repeat (100) @(posedge clock_i);
        convert_request_n_n <= 1'b1;
        do_reset(1'b0);
        t_wake();
        repeat (400) @(negedge clock_i);
        chk_word({23'h000000, ready_n}, 24'h000001);
        $display("abort test done");
    endtask
    task automatic t_sleep();
        @(posedge clock_i);
        slp_n <= 1'b0;
        repeat (2100) @(posedge clock_i);
        slp_n <= 1'b1;
        wait_ready(lag);
        chk_span(lag, 3083, 3092);
        $display("sleep test done");
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // about 9000 cycles are needed
    initial begin
        #300000;
        err_count++;
        $display("[FAIL] %0t run did not finish", $time);
        stop_test();
    end
    initial begin
        do_reset(1'b1);
        t_wake();
        t_single(1'b1, 24'hA5C3E1);
        t_held();
        t_abort();
        t_single(1'b0, 24'h3C0F96);
        t_sleep();
        stop_test();
    end
endmodule // test_adc_conversion_serial_readout
`default_nettype wire
